// >>> sim/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// External oscillators and free-running safe sources
module osc_model (
  input wire logic aclk,
  input wire logic hf_run,
  input wire logic lf_run,
  output logic hf_external_oscillator,
  output logic internal_48m_rc_oscillator,
  output logic lf_external_oscillator,
  output logic lf_external_oscillator_1k,
  output logic internal_ulp_32k_oscillator,
  output logic internal_ulp_1k_oscillator
);
  logic [4:0] cnt = 5'h00;
  initial begin
    hf_external_oscillator = 1'b0;
    internal_48m_rc_oscillator = 1'b0;
    lf_external_oscillator = 1'b0;
    lf_external_oscillator_1k = 1'b0;
    internal_ulp_32k_oscillator = 1'b0;
    internal_ulp_1k_oscillator = 1'b0;
  end
  // Safe sources run from time zero; a failed crystal sticks at its level
  always @(posedge aclk) begin
    cnt <= cnt + 5'h01;
    internal_48m_rc_oscillator <= ~internal_48m_rc_oscillator;
    internal_ulp_32k_oscillator <= ~internal_ulp_32k_oscillator;
    if (cnt == 5'h1f) begin
      internal_ulp_1k_oscillator <= ~internal_ulp_1k_oscillator;
    end
    if (hf_run) begin
      hf_external_oscillator <= ~hf_external_oscillator;
    end
    if (lf_run) begin
      lf_external_oscillator <= ~lf_external_oscillator;
    end
    if (lf_run && cnt == 5'h1f) begin
      lf_external_oscillator_1k <= ~lf_external_oscillator_1k;
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import clock_failure_detector_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic hf_external_oscillator, internal_48m_rc_oscillator, lf_external_oscillator;
  logic lf_external_oscillator_1k, internal_ulp_32k_oscillator, internal_ulp_1k_oscillator;
  logic sleep_mode = 1'b0, hf_osc_requested = 1'b1, lf_osc_requested = 1'b1;
  logic hf_run = 1'b1, lf_run = 1'b1;
  logic hf_clk_out, lf_clk32_out, lf_clk1k_out, hf_fail_event, lf_fail_event, irq;
  int error_cnt = 0;
  int n_tests = 0;
  int su = 0, t0 = 0;
  clock_failure_detector DUT (.*);
  osc_model partner (.*);
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic timed_out(input int n);
    if (n >= 300) begin
      error_cnt++;
      $display("MISMATCH wait exp answer seen none");
      close_out();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    // Idle edge between transfers
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 300);
    s_axi_bready <= 1'b0;
    timed_out(n);
    chk($sformatf("bresp %h", a), 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 300);
    s_axi_rready <= 1'b0;
    timed_out(n);
    chk($sformatf("rdata %h", a), s_axi_rdata, exp);
    chk($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(er));
  endtask
  task automatic wait_ev(input logic lf);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(lf ? lf_fail_event : hf_fail_event) && n < 300);
    timed_out(n);
  endtask
  // Safe clock must reach the output while the crystal is stuck
  task automatic toggles(input logic lf);
    int c;
    logic p, q;
    c = 0;
    p = lf ? lf_clk32_out : hf_clk_out;
    q = internal_ulp_1k_oscillator;
    repeat (16) begin
      @(posedge aclk);
      if ((lf ? lf_clk32_out : hf_clk_out) !== p) c++;
      if (lf) chk("clock 1k", 32'(lf_clk1k_out), 32'(q));
      p = lf ? lf_clk32_out : hf_clk_out;
      q = internal_ulp_1k_oscillator;
    end
    chk("clock toggles", 32'(c >= 4), 32'h1);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(13917));
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 7; i++) rd(5'(i * 4), 32'h0, RESP_OKAY);
    rd(5'h1c, 32'h0, RESP_SLVERR);
    wr(5'h1c, 32'h3, RESP_SLVERR);
    $display("test reset values done");
    wr(OFS_EVENT_CONTROL_REG, 32'h3, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE_SET_REG, 32'h1, RESP_OKAY);
    wr(OFS_HF_CTRL, 32'h3, RESP_OKAY);
    tick(30 + $urandom % 16);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    hf_run <= 1'b0;
    wait_ev(1'b0);
    chk("irq", 32'(irq), 32'h1);
    rd(OFS_STATUS, 32'h3, RESP_OKAY);
    rd(OFS_INTERRUPT_FLAG_REG, 32'h1, RESP_OKAY);
    toggles(1'b0);
    rd(OFS_HF_CTRL, 32'h3, RESP_OKAY);
    hf_run <= 1'b1;
    tick(40);
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    wr(OFS_INTERRUPT_FLAG_REG, 32'h1, RESP_OKAY);
    chk("irq", 32'(irq), 32'h0);
    $display("test hf failure done");
    wr(OFS_LF_CTRL, 32'h3 | (32'(1 + $urandom % 7) << 3), RESP_OKAY);
    rd(OFS_LF_CTRL, 32'hb, RESP_OKAY);
    wr(OFS_LF_CTRL, 32'h3, RESP_OKAY);
    tick(30 + $urandom % 16);
    lf_run <= 1'b0;
    wait_ev(1'b1);
    chk("irq", 32'(irq), 32'h0);
    rd(OFS_STATUS, 32'he, RESP_OKAY);
    rd(OFS_INTERRUPT_FLAG_REG, 32'h2, RESP_OKAY);
    toggles(1'b1);
    lf_run <= 1'b1;
    tick(40);
    wr(OFS_LF_CTRL, 32'h7, RESP_OKAY);
    tick(40);
    rd(OFS_LF_CTRL, 32'h3, RESP_OKAY);
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    wr(OFS_LF_CTRL, 32'h7, RESP_OKAY);
    rd(OFS_LF_CTRL, 32'h3, RESP_OKAY);
    $display("test lf switch back done");
    wr(OFS_INTERRUPT_FLAG_REG, 32'h3, RESP_OKAY);
    wr(OFS_HF_CTRL, 32'h2, RESP_OKAY);
    hf_run <= 1'b0;
    tick(60);
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    hf_run <= 1'b1;
    su = 3 + $urandom % 3;
    wr(OFS_HF_CTRL, 32'(su << 6) | 32'h3, RESP_OKAY);
    sleep_mode <= 1'b1;
    hf_osc_requested <= 1'b0;
    tick(20);
    hf_run <= 1'b0;
    tick(60);
    rd(OFS_INTERRUPT_FLAG_REG, 32'h0, RESP_OKAY);
    t0 = int'($time);
    hf_osc_requested <= 1'b1;
    wait_ev(1'b0);
    t0 = (int'($time) - t0) / 10;
    chk("start-up cycles", 32'(t0 >= (2 << su) && t0 <= (2 << su) + 16), 32'h1);
    $display("test gating done");
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    rd(OFS_HF_CTRL, 32'h0, RESP_OKAY);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire

// >>> verilog/clock_activity_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clock_activity_monitor
  import clock_failure_detector_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mon_clk,
  input wire logic safe_tick,
  input wire logic active,
  input wire logic [3:0] startup,
  output monitor_out_t result
);
  typedef enum logic [1:0] {IDLE, STARTUP, WATCH} mon_state_t;
  mon_state_t state, next_state;
  logic prev_mon, rise_seen, fall_seen, fail_status, fail_pulse;
  logic next_rise, next_fall, next_fail_status, next_fail_pulse;
  logic [WIN_W-1:0] win_cnt, next_win_cnt;
  logic [SU_W-1:0] su_cnt, next_su_cnt;
  logic rise_now, fall_now;

  assign rise_now = mon_clk & ~prev_mon;
  assign fall_now = ~mon_clk & prev_mon;
  assign result = '{fail_status: fail_status, fail_pulse: fail_pulse,
                    watching: state == WATCH};

  always_comb begin
    next_state = state;
    next_rise = rise_seen;
    next_fall = fall_seen;
    next_win_cnt = win_cnt;
    next_su_cnt = su_cnt;
    next_fail_status = fail_status;
    next_fail_pulse = 1'b0;
    case (state)
      IDLE: begin
        next_fail_status = 1'b0;
        if (active) begin
          next_state = STARTUP;
          next_su_cnt = '0;
        end
      end
      STARTUP: begin
        if (!active) begin
          next_state = IDLE;
        end else if (safe_tick) begin
          if (su_cnt == (SU_ONE << startup) - SU_ONE) begin
            next_state = WATCH;
            next_win_cnt = '0;
            next_rise = 1'b0;
            next_fall = 1'b0;
          end else begin
            next_su_cnt = su_cnt + SU_ONE;
          end
        end
      end
      WATCH: begin
        if (!active) begin
          next_state = IDLE;
          next_fail_status = 1'b0;
        end else begin
          next_rise = rise_seen | rise_now;
          next_fall = fall_seen | fall_now;
          if (safe_tick) begin
            if (win_cnt == WIN_LAST) begin
              next_fail_status = ~(next_rise & next_fall);
              next_fail_pulse = ~(next_rise & next_fall);
              next_win_cnt = '0;
              next_rise = rise_now;
              next_fall = fall_now;
            end else begin
              next_win_cnt = win_cnt + 1'b1;
            end
          end
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= IDLE;
      prev_mon <= 1'b0;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
      win_cnt <= '0;
      su_cnt <= '0;
      fail_status <= 1'b0;
      fail_pulse <= 1'b0;
    end else begin
      state <= next_state;
      prev_mon <= mon_clk;
      rise_seen <= next_rise;
      fall_seen <= next_fall;
      win_cnt <= next_win_cnt;
      su_cnt <= next_su_cnt;
      fail_status <= next_fail_status;
      fail_pulse <= next_fail_pulse;
    end
  end

  // ==========================================
  // Checks
  window_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fail_pulse |-> $past(state) == WATCH && $past(win_cnt) == WIN_LAST && $past(safe_tick))
    else $error("failure reported outside a window end");
  idle_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !active |=> !fail_status && !fail_pulse)
    else $error("failure shown while monitor inactive");
  startup_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == STARTUP |=> !fail_pulse)
    else $error("failure reported during start-up");
  fail_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) fail_pulse);
endmodule
`default_nettype wire

// >>> verilog/clock_failure_detector.sv
`timescale 1ns/1ps
`default_nettype none
module clock_failure_detector
  import clock_failure_detector_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hf_external_oscillator,
  input wire logic internal_48m_rc_oscillator,
  input wire logic lf_external_oscillator,
  input wire logic lf_external_oscillator_1k,
  input wire logic internal_ulp_32k_oscillator,
  input wire logic internal_ulp_1k_oscillator,
  input wire logic sleep_mode,
  input wire logic hf_osc_requested,
  input wire logic lf_osc_requested,
  output logic hf_clk_out,
  output logic lf_clk32_out,
  output logic lf_clk1k_out,
  output logic hf_fail_event,
  output logic lf_fail_event,
  output logic irq
);
  // ==========================================
  // Register state
  osc_ctl_t hf_osc_control_reg, failure_detect_control_reg;
  osc_ctl_t next_hf_ctl, next_lf_ctl, wr_ctl;
  logic [NUM_SRC-1:0] event_control_reg, interrupt_enable_set_reg, interrupt_flag_reg;
  logic [NUM_SRC-1:0] next_event_control_reg, next_inten, next_interrupt_flag_reg, fail_pulse;
  logic hf_switched, lf_switched, next_hf_switched, next_lf_switched;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr;
  logic [31:0] wdata_q, next_wdata, wmask, wbits, rd_word, next_rdata;
  logic [3:0] wstrb_q, next_wstrb;
  logic next_bvalid, next_rvalid, rd_hit, do_write;
  logic [1:0] next_bresp, next_rresp;
  logic [3:0] status_word;
  monitor_out_t hf_res, lf_res;
  logic hf_active, lf_active;

  // ==========================================
  // Safe clock generation
  logic rc_prev, ulp32_prev, ulp1k_prev, lf_div32, lf_div1k;
  logic next_lf_div32, next_lf_div1k, safe_hf_prev, safe_lf_prev;
  logic [HF_DIV_W-1:0] hf_div_cnt, next_hf_div_cnt;
  logic safe_hf, safe_lf32, safe_lf1k, safe_hf_tick, safe_lf_tick;

  always_comb begin
    next_hf_div_cnt = hf_div_cnt;
    next_lf_div32 = lf_div32;
    next_lf_div1k = lf_div1k;
    if (internal_48m_rc_oscillator && !rc_prev) begin
      next_hf_div_cnt = hf_div_cnt + 1'b1;
    end
    if (internal_ulp_32k_oscillator && !ulp32_prev) begin
      next_lf_div32 = ~lf_div32;
    end
    if (internal_ulp_1k_oscillator && !ulp1k_prev) begin
      next_lf_div1k = ~lf_div1k;
    end
    if (hf_osc_control_reg.presc == '0) begin
      safe_hf = internal_48m_rc_oscillator;
    end else begin
      safe_hf = hf_div_cnt[hf_osc_control_reg.presc - 3'h1];
    end
    if (failure_detect_control_reg.presc == '0) begin
      safe_lf32 = internal_ulp_32k_oscillator;
      safe_lf1k = internal_ulp_1k_oscillator;
    end else begin
      safe_lf32 = lf_div32;
      safe_lf1k = lf_div1k;
    end
  end

  assign safe_hf_tick = safe_hf & ~safe_hf_prev;
  assign safe_lf_tick = safe_lf32 & ~safe_lf_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_prev <= 1'b0;
      ulp32_prev <= 1'b0;
      ulp1k_prev <= 1'b0;
      hf_div_cnt <= '0;
      lf_div32 <= 1'b0;
      lf_div1k <= 1'b0;
      safe_hf_prev <= 1'b0;
      safe_lf_prev <= 1'b0;
    end else begin
      rc_prev <= internal_48m_rc_oscillator;
      ulp32_prev <= internal_ulp_32k_oscillator;
      ulp1k_prev <= internal_ulp_1k_oscillator;
      hf_div_cnt <= next_hf_div_cnt;
      lf_div32 <= next_lf_div32;
      lf_div1k <= next_lf_div1k;
      safe_hf_prev <= safe_hf;
      safe_lf_prev <= safe_lf32;
    end
  end

  // ==========================================
  // Activity monitors
  assign hf_active = hf_osc_control_reg.osc_en & hf_osc_control_reg.det_en
                   & ~(sleep_mode & ~hf_osc_requested);
  assign lf_active = failure_detect_control_reg.osc_en & failure_detect_control_reg.det_en
                   & ~(sleep_mode & ~lf_osc_requested);
  assign fail_pulse = {lf_res.fail_pulse, hf_res.fail_pulse};

  clock_activity_monitor hf_monitor (
    .aclk(aclk),
    .aresetn(aresetn),
    .mon_clk(hf_external_oscillator),
    .safe_tick(safe_hf_tick),
    .active(hf_active),
    .startup(hf_osc_control_reg.startup),
    .result(hf_res)
  );

  clock_activity_monitor lf_monitor (
    .aclk(aclk),
    .aresetn(aresetn),
    .mon_clk(lf_external_oscillator),
    .safe_tick(safe_lf_tick),
    .active(lf_active),
    .startup(failure_detect_control_reg.startup),
    .result(lf_res)
  );

  // ==========================================
  // Bus slave and registers
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits = wdata_q & wmask;
  assign status_word = {lf_switched, lf_res.fail_status, hf_switched, hf_res.fail_status};
  assign irq = |(interrupt_flag_reg & interrupt_enable_set_reg);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr = awaddr_q;
    next_wdata = wdata_q;
    next_wstrb = wstrb_q;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_hf_ctl = hf_osc_control_reg;
    next_lf_ctl = failure_detect_control_reg;
    next_event_control_reg = event_control_reg;
    next_inten = interrupt_enable_set_reg;
    next_interrupt_flag_reg = interrupt_flag_reg;
    next_hf_switched = hf_switched;
    next_lf_switched = lf_switched;
    wr_ctl = osc_ctl_t'(wbits[CTL_W-1:0]);
    rd_word = '0;
    rd_hit = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (awaddr_q)
        OFS_HF_CTRL: begin
          next_hf_ctl = osc_ctl_t'((hf_osc_control_reg & ~wmask[CTL_W-1:0]) | wr_ctl);
          next_hf_ctl.switch_back_request_bit = 1'b0;
        end
        OFS_LF_CTRL: begin
          next_lf_ctl = osc_ctl_t'((failure_detect_control_reg & ~wmask[CTL_W-1:0])
                                   | wbits[CTL_W-1:0]);
          next_lf_ctl.presc = (next_lf_ctl.presc != '0) ? LF_PRESC_MAX : '0;
        end
        OFS_EVENT_CONTROL_REG: next_event_control_reg = (event_control_reg & ~wmask[NUM_SRC-1:0]) | wbits[NUM_SRC-1:0];
        OFS_INTERRUPT_ENABLE_SET_REG: next_inten = interrupt_enable_set_reg | wbits[NUM_SRC-1:0];
        OFS_INTENCLR: next_inten = interrupt_enable_set_reg & ~wbits[NUM_SRC-1:0];
        OFS_INTERRUPT_FLAG_REG: next_interrupt_flag_reg = interrupt_flag_reg & ~wbits[NUM_SRC-1:0];
        OFS_STATUS: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    next_interrupt_flag_reg = next_interrupt_flag_reg | fail_pulse;
    if (hf_res.fail_pulse) begin
      next_hf_switched = 1'b1;
    end
    if (failure_detect_control_reg.switch_back_request_bit) begin
      if (!lf_switched) begin
        next_lf_ctl.switch_back_request_bit = 1'b0;
      end else if (lf_res.watching && !lf_res.fail_status) begin
        next_lf_switched = 1'b0;
        next_lf_ctl.switch_back_request_bit = 1'b0;
      end
    end
    if (lf_res.fail_pulse) begin
      next_lf_switched = 1'b1;
    end
    case (s_axi_araddr)
      OFS_HF_CTRL: rd_word[CTL_W-1:0] = hf_osc_control_reg;
      OFS_LF_CTRL: rd_word[CTL_W-1:0] = failure_detect_control_reg;
      OFS_EVENT_CONTROL_REG: rd_word[NUM_SRC-1:0] = event_control_reg;
      OFS_INTERRUPT_ENABLE_SET_REG: rd_word[NUM_SRC-1:0] = interrupt_enable_set_reg;
      OFS_INTENCLR: rd_word[NUM_SRC-1:0] = interrupt_enable_set_reg;
      OFS_INTERRUPT_FLAG_REG: rd_word[NUM_SRC-1:0] = interrupt_flag_reg;
      OFS_STATUS: rd_word[3:0] = status_word;
      default: rd_hit = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Reset whenever aresetn is low; no other reset reaches this state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      hf_osc_control_reg <= OSC_CTL_RESET;
      failure_detect_control_reg <= OSC_CTL_RESET;
      event_control_reg <= '0;
      interrupt_enable_set_reg <= '0;
      interrupt_flag_reg <= '0;
      hf_switched <= 1'b0;
      lf_switched <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr;
      wdata_q <= next_wdata;
      wstrb_q <= next_wstrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      hf_osc_control_reg <= next_hf_ctl;
      failure_detect_control_reg <= next_lf_ctl;
      event_control_reg <= next_event_control_reg;
      interrupt_enable_set_reg <= next_inten;
      interrupt_flag_reg <= next_interrupt_flag_reg;
      hf_switched <= next_hf_switched;
      lf_switched <= next_lf_switched;
    end
  end

  // ==========================================
  // Clock outputs and events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_clk_out <= 1'b0;
      lf_clk32_out <= 1'b0;
      lf_clk1k_out <= 1'b0;
      hf_fail_event <= 1'b0;
      lf_fail_event <= 1'b0;
    end else begin
      hf_clk_out <= hf_switched ? safe_hf : hf_external_oscillator;
      lf_clk32_out <= lf_switched ? safe_lf32 : lf_external_oscillator;
      lf_clk1k_out <= lf_switched ? safe_lf1k : lf_external_oscillator_1k;
      hf_fail_event <= hf_res.fail_pulse & event_control_reg[SRC_HF];
      lf_fail_event <= lf_res.fail_pulse & event_control_reg[SRC_LF];
    end
  end

  // ==========================================
  // Checks
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hf_res.fail_pulse |=> interrupt_flag_reg[SRC_HF] && hf_switched)
    else $error("failure did not set flag and switch");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hf_res.fail_pulse && interrupt_enable_set_reg[SRC_HF] && !do_write |=> irq)
    else $error("enabled failure gave no interrupt");
  event_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hf_res.fail_pulse |=> hf_fail_event == $past(event_control_reg[SRC_HF]))
    else $error("failure event does not follow its enable");
  hf_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hf_switched |=> hf_clk_out == $past(safe_hf))
    else $error("switched output not on safe clock");
  lf_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lf_switched |=> lf_clk1k_out == $past(safe_lf1k) && lf_clk32_out == $past(safe_lf32))
    else $error("low-frequency outputs not on safe clock");
  switch_back_request_bit_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    failure_detect_control_reg.switch_back_request_bit && !lf_switched && !do_write |=>
      !failure_detect_control_reg.switch_back_request_bit)
    else $error("switch-back bit not cleared");
  presc_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
    failure_detect_control_reg.presc <= LF_PRESC_MAX)
    else $error("low-frequency divider above two");
  sleep_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_mode && !hf_osc_requested |=> !hf_res.fail_pulse)
    else $error("detection ran in sleep without request");
  hf_fail_c: cover property (@(posedge aclk) disable iff (!aresetn) hf_res.fail_pulse ##1 irq);
  switch_back_request_bit_c: cover property (@(posedge aclk) disable iff (!aresetn) $fell(lf_switched));
  lf_event_c: cover property (@(posedge aclk) disable iff (!aresetn) lf_fail_event);
endmodule
`default_nettype wire

// >>> verilog/clock_failure_detector_pkg.sv
package clock_failure_detector_pkg;
  // ==========================================
  // Register map
  localparam logic [4:0] OFS_HF_CTRL = 5'h00;
  localparam logic [4:0] OFS_LF_CTRL = 5'h04;
  localparam logic [4:0] OFS_EVENT_CONTROL_REG = 5'h08;
  localparam logic [4:0] OFS_INTERRUPT_ENABLE_SET_REG = 5'h0c;
  localparam logic [4:0] OFS_INTENCLR = 5'h10;
  localparam logic [4:0] OFS_INTERRUPT_FLAG_REG = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam int ADDR_W = 5;
  localparam int NUM_SRC = 2;
  localparam int SRC_HF = 0;
  localparam int SRC_LF = 1;
  localparam int ST_HF_FAIL = 0;
  localparam int ST_HF_SW = 1;
  localparam int ST_LF_FAIL = 2;
  localparam int ST_LF_SW = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // Oscillator control layout, top bit downward (osc_en is bit 0)
  typedef struct packed {
    logic [3:0] startup;
    logic [2:0] presc;
    logic switch_back_request_bit;
    logic det_en;
    logic osc_en;
  } osc_ctl_t;
  localparam int CTL_W = $bits(osc_ctl_t);
  localparam osc_ctl_t OSC_CTL_RESET = '0;
  localparam logic [2:0] LF_PRESC_MAX = 3'h1;
  // ==========================================
  // Monitor timing
  localparam int WIN_W = 2;
  localparam logic [WIN_W-1:0] WIN_LAST = 2'h3;
  localparam int SU_W = 16;
  localparam logic [SU_W-1:0] SU_ONE = 16'h0001;
  localparam int HF_DIV_W = 7;
  typedef struct packed {
    logic fail_status;
    logic fail_pulse;
    logic watching;
  } monitor_out_t;
endpackage
